/* shared/ssr_pkg.sv */
// constants, carrier types and register map of the jk shift register block
// Notes on behaviour
// R1 - load-select low: edge copies parallel inputs in
// R2 - clear low: stages low, inverted output high
// R3 - load-select high: edge shifts stage n to n+1
// R4 - serial pair sets, clears, toggles or keeps stage0
// R5 - transfers only on a low-to-high clock edge
// R6 - far side may tie serial pair together
// R7 - far side may wire outputs back to shift left
// R8 - after clear, contents hold until next edge
package ssr_pkg;

    // ==========================================================
    // sizes
    localparam int unsigned STAGES = 4;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned LEVEL_W = $clog2(FIFO_DEPTH + 1);
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] CTRL_OFFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFS = 8'h04;
    localparam logic [ADDR_W-1:0] DATA_OFFS = 8'h08;

    // ==========================================================
    // field positions
    localparam int unsigned CTRL_CAPTURE_BIT = 0;
    localparam int unsigned STATUS_STAGE_LSB = 0;
    localparam int unsigned STATUS_INV_BIT = 4;
    localparam int unsigned STATUS_VALID_BIT = 5;
    localparam int unsigned STATUS_FULL_BIT = 6;
    localparam int unsigned STATUS_OVF_BIT = 7;
    localparam int unsigned STATUS_LEVEL_LSB = 8;
    localparam int unsigned DATA_VALID_BIT = 31;

    // ==========================================================
    // values after reset
    localparam logic [STAGES-1:0] STAGE_RST = 4'h0;
    localparam logic INV_RST = 1'b1;
    localparam logic CLK_PREV_RST = 1'b1;
    localparam logic CAPTURE_RST = 1'b1;
    localparam logic OVF_RST = 1'b0;

    // ==========================================================
    // types
    typedef struct packed {
        logic jSet;
        logic kInvKeep;
    } ssr_serial_t;

    typedef struct packed {
        logic [STAGES-1:0] stages;
        logic lastInv;
    } ssr_snap_t;

    localparam int unsigned SNAP_W = $bits(ssr_snap_t);

    typedef enum {
        OP_IDLE,
        OP_LOAD,
        OP_SHIFT
    } ssr_op_t;

endpackage : ssr_pkg

/* rtl/ssr_fifo.sv */
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module ssr_fifo #(
    parameter int unsigned WIDTH = 5,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH+1)-1:0] level
);

    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtrReg;
    logic [AW-1:0] rdPtrReg;
    logic [CW-1:0] countReg;
    logic [CW-1:0] countNext;
    logic inReadyReg;
    logic outValidReg;
    logic push;
    logic pop;

    // ==========================================================
    // handshakes
    assign push = inValid & inReadyReg;
    assign pop = outValidReg & outReady;
    assign inReady = inReadyReg;
    assign outValid = outValidReg;
    assign outData = mem[rdPtrReg];
    assign level = countReg;

    always_comb
    begin
        countNext = countReg;
        if (push && !pop)
        begin
            countNext = countReg + CW'(1);
        end
        else if (pop && !push)
        begin
            countNext = countReg - CW'(1);
        end
    end

    // ==========================================================
    // pointers and flags; flags are registered so full and empty never glitch
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            wrPtrReg <= '0;
            rdPtrReg <= '0;
            countReg <= '0;
            inReadyReg <= 1'b1;
            outValidReg <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wrPtrReg <= (wrPtrReg == AW'(DEPTH - 1)) ? '0 : wrPtrReg + AW'(1);
            end
            if (pop)
            begin
                rdPtrReg <= (rdPtrReg == AW'(DEPTH - 1)) ? '0 : rdPtrReg + AW'(1);
            end
            countReg <= countNext;
            inReadyReg <= (countNext != CW'(DEPTH));
            outValidReg <= (countNext != '0);
        end
    end

    // ==========================================================
    // storage, no reset needed: only read while counted valid
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtrReg] <= inData;
        end
    end

endmodule : ssr_fifo

/* rtl/ssr_jk_shift_reg.sv */
// four-stage jk-fed shift register with apb access and snapshot fifo
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ssr_jk_shift_reg (
    input wire logic mclk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ssr_pkg::ADDR_W-1:0] paddr,
    input wire logic [ssr_pkg::DATA_W-1:0] pwdata,
    output logic [ssr_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // shift register pins
    input wire logic clockPulseIn,
    input wire logic loadSelectN,
    input wire logic clearN,
    input wire ssr_pkg::ssr_serial_t serialIn,
    input wire logic [ssr_pkg::STAGES-1:0] parallelIn,
    output logic [ssr_pkg::STAGES-1:0] stageOut,
    output logic lastStageInv,
    output logic captureReady
);
    import ssr_pkg::*;

    // ==========================================================
    // declarations
    logic coreRstN;
    logic cpPrevReg;
    logic cpRise;
    ssr_op_t opNow;
    logic firstNext;
    logic [STAGES-1:0] stageReg;
    logic [STAGES-1:0] stageNext;
    logic invReg;

    logic captureEnReg;
    logic ovfReg;
    ssr_snap_t snapIn;
    ssr_snap_t snapOut;
    logic pushReq;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [LEVEL_W-1:0] fifoLevel;

    logic setupPhase;
    logic accessDone;
    logic [DATA_W-1:0] rdValue;
    logic errNow;
    logic [DATA_W-1:0] prdataReg;
    logic preadyReg;
    logic pslverrReg;
    logic popArmReg;
    logic ovfClear;

    // ==========================================================
    // clear and reset
    // clear is asynchronous by nature, so it joins the reset tree
    // instead of being sampled; a gated reset is the price of that
    assign coreRstN = nrst & clearN; // R2

    // ==========================================================
    // edge detection on the register clock pin
    always_ff @(posedge mclk or negedge coreRstN)
    begin
        if (!coreRstN)
        begin
            cpPrevReg <= CLK_PREV_RST;
        end
        else
        begin
            cpPrevReg <= clockPulseIn;
        end
    end

    // prev resets high so a pin already high at clear release is no edge
    assign cpRise = clockPulseIn & ~cpPrevReg; // R5 R8

    // ==========================================================
    // operation decode
    always_comb
    begin
        opNow = OP_IDLE;
        if (cpRise)
        begin
            if (loadSelectN)
            begin
                opNow = OP_SHIFT; // R3
            end
            else
            begin
                opNow = OP_LOAD; // R1
            end
        end
    end

    // set when j high and stage low, keep when k-bar high and stage high;
    // a tied pair therefore acts as a plain data input
    assign firstNext = (serialIn.jSet & ~stageReg[0])
        | (serialIn.kInvKeep & stageReg[0]); // R4 R6

    always_comb
    begin
        stageNext = stageReg;
        case (opNow)
            OP_LOAD:
            begin
                stageNext = parallelIn; // R1 R7
            end
            OP_SHIFT:
            begin
                stageNext = {stageReg[STAGES-2:0], firstNext}; // R3
            end
            OP_IDLE:
            begin
                stageNext = stageReg; // R5 R8
            end
            default:
            begin
                stageNext = stageReg;
            end
        endcase
    end

    // ==========================================================
    // stages and inverted last stage
    always_ff @(posedge mclk or negedge coreRstN)
    begin
        if (!coreRstN)
        begin
            stageReg <= STAGE_RST; // R2
            invReg <= INV_RST; // R2
        end
        else
        begin
            stageReg <= stageNext;
            invReg <= ~stageNext[STAGES-1]; // R1 R3
        end
    end

    assign stageOut = stageReg;
    assign lastStageInv = invReg;

    // ==========================================================
    // snapshot capture
    assign snapIn.stages = stageNext;
    assign snapIn.lastInv = ~stageNext[STAGES-1];
    assign pushReq = captureEnReg && (opNow != OP_IDLE);

    ssr_fifo #(
        .WIDTH(SNAP_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rstN(nrst),
        .inValid(pushReq),
        .inReady(fifoInReady),
        .inData(snapIn),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(snapOut),
        .level(fifoLevel)
    );

    assign captureReady = fifoInReady;

    // ==========================================================
    // apb read mux
    assign setupPhase = psel & ~penable;
    assign accessDone = psel & penable & preadyReg;

    always_comb
    begin
        rdValue = '0;
        errNow = 1'b0;
        case (paddr)
            CTRL_OFFS:
            begin
                rdValue[CTRL_CAPTURE_BIT] = captureEnReg;
            end
            STATUS_OFFS:
            begin
                rdValue[STATUS_STAGE_LSB +: STAGES] = stageReg;
                rdValue[STATUS_INV_BIT] = invReg;
                rdValue[STATUS_VALID_BIT] = fifoOutValid;
                rdValue[STATUS_FULL_BIT] = ~fifoInReady;
                rdValue[STATUS_OVF_BIT] = ovfReg;
                rdValue[STATUS_LEVEL_LSB +: LEVEL_W] = fifoLevel;
            end
            DATA_OFFS:
            begin
                rdValue[SNAP_W-1:0] = snapOut;
                rdValue[DATA_VALID_BIT] = fifoOutValid;
            end
            default:
            begin
                errNow = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // apb answer: no wait state, data fixed in the setup cycle
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            prdataReg <= '0;
            preadyReg <= 1'b0;
            pslverrReg <= 1'b0;
            popArmReg <= 1'b0;
        end
        else
        begin
            preadyReg <= setupPhase;
            pslverrReg <= setupPhase & errNow;
            popArmReg <= setupPhase & ~pwrite & (paddr == DATA_OFFS) & fifoOutValid;
            if (setupPhase)
            begin
                prdataReg <= pwrite ? '0 : rdValue;
            end
        end
    end

    assign prdata = prdataReg;
    assign pready = preadyReg;
    assign pslverr = pslverrReg;

    // only a read that saw a valid word pops, so no word is lost
    assign fifoOutReady = accessDone & popArmReg;

    // ==========================================================
    // apb writes
    assign ovfClear = accessDone & pwrite & (paddr == STATUS_OFFS) & pwdata[STATUS_OVF_BIT];

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            captureEnReg <= CAPTURE_RST;
        end
        else if (accessDone && pwrite && paddr == CTRL_OFFS)
        begin
            captureEnReg <= pwdata[CTRL_CAPTURE_BIT];
        end
    end

    // a snapshot refused by a full fifo marks overflow; set beats clear
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ovfReg <= OVF_RST;
        end
        else
        begin
            ovfReg <= (pushReq & ~fifoInReady) | (ovfReg & ~ovfClear);
        end
    end

endmodule : ssr_jk_shift_reg

/* tb/ssr_jk_shift_reg_sva.sv */
// assertion checker for the shift register pins and the apb handshake
`timescale 1ns/1ps
module ssr_jk_shift_reg_sva (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic clockPulseIn,
    input wire logic loadSelectN,
    input wire logic clearN,
    input wire ssr_pkg::ssr_serial_t serialIn,
    input wire logic [ssr_pkg::STAGES-1:0] parallelIn,
    input wire logic [ssr_pkg::STAGES-1:0] stageOut,
    input wire logic lastStageInv
);
    import ssr_pkg::*;
    logic pinQ, clrQ, xfer, jkNext;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ====
    // helpers
    // a rise counts only with clear off at both samples, as the edge detector restarts high
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            {pinQ, clrQ} <= 2'b10;
        end
        else
        begin
            {pinQ, clrQ} <= {clockPulseIn, clearN};
        end
    end
    assign xfer = clockPulseIn & ~pinQ & clearN & clrQ;
    assign jkNext = serialIn.jSet & ~stageOut[0] | serialIn.kInvKeep & stageOut[0];
    // ====
    // properties
    AST_LOAD: assert property (xfer && !loadSelectN |=> stageOut == $past(parallelIn))
        else $error("load did not copy the parallel inputs");
    AST_SHIFT: assert property (xfer && loadSelectN |=> stageOut[3:1] == $past(stageOut[2:0]))
        else $error("shift did not move the stages up");
    AST_JK: assert property (xfer && loadSelectN |=> stageOut[0] == $past(jkNext))
        else $error("first stage ignored the serial pair");
    AST_HOLD: assert property (clearN && !xfer |=> !clearN || $stable(stageOut))
        else $error("stages changed without a clock rise");
    AST_INV: assert property (lastStageInv == ~stageOut[3])
        else $error("inverted output not the complement of the last stage");
    AST_CLEAR: assert property (!clearN |-> stageOut == 4'h0 && lastStageInv)
        else $error("clear did not force the outputs");
    AST_CLR_HOLD: assert property ($rose(clearN) ##1 !xfer |=> stageOut == 4'h0)
        else $error("cleared contents lost without a transfer");
    AST_PREADY: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
endmodule : ssr_jk_shift_reg_sva

bind ssr_jk_shift_reg ssr_jk_shift_reg_sva u_sva (.mclk(mclk), .nrst(nrst), .psel(psel),
    .penable(penable), .pready(pready), .clockPulseIn(clockPulseIn),
    .loadSelectN(loadSelectN), .clearN(clearN), .serialIn(serialIn),
    .parallelIn(parallelIn), .stageOut(stageOut), .lastStageInv(lastStageInv));

/* tb/ssr_far_logic.sv */
// far-side logic model driving mode, serial pair, data and clear
`timescale 1ns/1ps
module ssr_far_logic (
    input wire logic mclk,
    input wire logic [ssr_pkg::STAGES-1:0] stageOut,
    output logic clockPulseIn,
    output logic loadSelectN,
    output logic clearN,
    output ssr_pkg::ssr_serial_t serialIn,
    output logic [ssr_pkg::STAGES-1:0] parallelIn
);
    import ssr_pkg::*;
    // ====
    // drivers
    initial
    begin
        clockPulseIn = 1'b0;
        loadSelectN = 1'b1;
        clearN = 1'b1;
        serialIn = '0;
        parallelIn = '0;
    end
    // one low sample then one high sample, so exactly one rise per call
    task automatic step(input logic ld, input ssr_serial_t s, input logic [STAGES-1:0] p);
        @(posedge mclk);
        clockPulseIn <= 1'b0;
        loadSelectN <= ld;
        serialIn <= s;
        parallelIn <= p;
        @(posedge mclk);
        clockPulseIn <= 1'b1;
        @(posedge mclk);
        clockPulseIn <= 1'b0;
        loadSelectN <= ~ld;
        serialIn <= ~s;
        parallelIn <= ~p;
    endtask : step
    task automatic dser(input logic d);
        step(1'b1, {d, d}, parallelIn);
    endtask : dser
    // stage d3 has no upper neighbour, so it takes zero
    task automatic shl();
        step(1'b0, '0, {1'b0, stageOut[3:1]});
    endtask : shl
    task automatic clr(input logic v);
        @(posedge mclk);
        clearN <= v;
    endtask : clr
endmodule : ssr_far_logic

/* tb/ssr_jk_shift_reg_tb_top.sv */
// self-checking bench for the jk shift register with apb and snapshot fifo
`timescale 1ns/1ps
module ssr_jk_shift_reg_tb_top;
    import ssr_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata, rd;
    logic pready, pslverr, er, clockPulseIn, loadSelectN, clearN, lastStageInv, captureReady;
    ssr_serial_t serialIn;
    logic [STAGES-1:0] parallelIn, stageOut;
    logic [STAGES-1:0] m = '0;
    int failures = 0;
    int nTests = 0;
    int cyc = 0;
    // ====
    // structure
    ssr_jk_shift_reg DUT (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clockPulseIn(clockPulseIn), .loadSelectN(loadSelectN),
        .clearN(clearN), .serialIn(serialIn), .parallelIn(parallelIn), .stageOut(stageOut),
        .lastStageInv(lastStageInv), .captureReady(captureReady));
    ssr_far_logic far (.mclk(mclk), .stageOut(stageOut), .clockPulseIn(clockPulseIn),
        .loadSelectN(loadSelectN), .clearN(clearN), .serialIn(serialIn),
        .parallelIn(parallelIn));
    always #50 mclk = ~mclk;
    // ====
    // helpers
    task automatic chk(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        nTests++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // let the transfer edge settle before looking
    task automatic see();
        #1;
        chk({27'h0, ~m[3], m}, {27'h0, lastStageInv, stageOut});
    endtask : see
    task automatic go(input logic ld, input ssr_serial_t s, input logic [STAGES-1:0] p);
        far.step(ld, s, p);
        m = ld ? {m[2:0], s.jSet & ~m[0] | s.kInvKeep & m[0]} : p;
        see();
    endtask : go
    // ====
    // scenarios
    task automatic t_fifo();
        for (int i = 0; i < 9; i++)
            go(1'b0, '0, i[3:0]);
        chk(32'h0, {31'h0, captureReady});
        apb(1'b0, STATUS_OFFS, '0);
        chk({20'h0, 4'h8, 3'h7, ~m[3], m}, rd);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, DATA_OFFS, '0);
            chk({1'b1, 26'h0, i[3:0], ~i[3]}, rd);
        end
        apb(1'b0, DATA_OFFS, '0);
        chk(32'h0, {31'h0, rd[31]});
        apb(1'b1, STATUS_OFFS, 32'h80);
        apb(1'b0, STATUS_OFFS, '0);
        chk({27'h0, ~m[3], m}, rd);
        apb(1'b1, CTRL_OFFS, 32'h0);
        apb(1'b0, CTRL_OFFS, '0);
        chk(32'h0, rd);
        apb(1'b0, 8'h0c, '0);
        chk(32'h1, {31'h0, er});
        chk(32'h0, rd);
    endtask : t_fifo
    task automatic t_shift();
        go(1'b0, '0, 4'ha);
        for (int i = 0; i < 8; i++)
            go(1'b1, ssr_serial_t'(i[2:1]), 4'h0);
        repeat (2) @(posedge mclk);
        see();
        far.dser(1'b1);
        m = {m[2:0], 1'b1};
        see();
        far.shl();
        m = {1'b0, m[3:1]};
        see();
    endtask : t_shift
    task automatic t_clear();
        go(1'b0, '0, 4'hf);
        far.clr(1'b0);
        m = 4'h0;
        see();
        far.step(1'b0, '0, 4'h9);
        see();
        far.clr(1'b1);
        repeat (3) @(posedge mclk);
        see();
        go(1'b0, '0, 4'h6);
    endtask : t_clear
    // mid-run reset must restore the apb registers and the fifo, not only the stages
    task automatic t_reset();
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        m = 4'h0;
        see();
        chk(32'h1, {31'h0, captureReady});
        apb(1'b0, CTRL_OFFS, '0);
        chk(32'h1, rd);
        apb(1'b0, STATUS_OFFS, '0);
        chk({27'h0, ~m[3], m}, rd);
    endtask : t_reset
    // ====
    // run control
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", nTests, failures);
        if (failures == 0 && nTests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            failures++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        t_fifo();
        t_shift();
        t_clear();
        t_reset();
        tally_and_finish();
    end
endmodule : ssr_jk_shift_reg_tb_top
